// ===== bench/mcyc_seq_asserts.sv
// Checker for the machine cycle sequencer, bound to its top module.
// Assumes the hand-over port timing and a single clock domain.
`timescale 1ns/1ps
module mcyc_seq_asserts (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Watched outputs
  input wire logic [7:0] clock_control_register_o,
  input mcyc_pkg::mcyc_phase_t phase_o,
  input wire logic fetch_o,
  input wire logic insn_done_o,
  input wire logic core_hold_o,
  input mcyc_pkg::mcyc_xbus_t xbus_o
);
  import mcyc_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic lo;
  logic [4:0] cnt_q, cnt_d;
  logic [2:0] st_q, st_d;
  assign lo = !xbus_o.rd_n || !xbus_o.wr_n;
  // Stretch is latched at the fetch, as a write during a move must not count.
  always_comb
  begin
    cnt_d = lo ? cnt_q + 5'h01 : 5'h00;
    st_d = fetch_o ? clock_control_register_o[2:0] : st_q;
  end
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cnt_q <= 5'h00;
      st_q <= 3'h1;
    end
    else
    begin
      cnt_q <= cnt_d;
      st_q <= st_d;
    end
  end
  ////////////////////////////////////////////////////////////
  AST_STROBE_WIDTH:
    assert property ($fell(lo) |-> cnt_q == (st_q == 3'h0 ? 5'h02 : {st_q, 2'b00}))
    else $error("Strobe width wrong.");
  AST_READ_EXCL:
    assert property (!xbus_o.rd_n |-> xbus_o.wr_n && !xbus_o.wdata_oe)
    else $error("Read overlaps write.");
  AST_ADDR_SETUP:
    assert property ($rose(lo) |-> $past(xbus_o.addr_valid))
    else $error("No address before strobe.");
  AST_ADDR_HOLD:
    assert property ($fell(lo) |-> xbus_o.addr_valid)
    else $error("Address dropped with strobe.");
  AST_ADDR_STABLE:
    assert property (lo && $past(lo) |-> $stable(xbus_o.addr))
    else $error("Address moved in strobe.");
  AST_HOLD_ACCESS:
    assert property (lo |-> core_hold_o && !fetch_o)
    else $error("Core not held in access.");
  AST_FETCH_GAP:
    assert property (fetch_o |=> !fetch_o [*3])
    else $error("Fetches closer than four clocks.");
  AST_PHASE_ORDER:
    assert property ($past(reset_n_i) |-> phase_o == {$past(phase_o[0]), ~$past(phase_o[1])})
    else $error("Phase out of order.");
  AST_DONE_AFTER:
    assert property ($fell(lo) |-> ##[1:8] insn_done_o)
    else $error("Move did not finish.");
endmodule : mcyc_seq_asserts

bind mcyc_seq mcyc_seq_asserts mcyc_seq_asserts_inst (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .clock_control_register_o(clock_control_register_o),
  .phase_o(phase_o), .fetch_o(fetch_o), .insn_done_o(insn_done_o),
  .core_hold_o(core_hold_o), .xbus_o(xbus_o)
);

// ===== bench/mcyc_seq_test.sv
// Testbench for the machine cycle sequencer with an external memory model.
// Assumes the hand-over timing; expected results wait in queues.
`timescale 1ns/1ps
module mcyc_seq_test;
  import mcyc_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic ccr_we_i = 1'b0;
  logic [7:0] ccr_wdata_i = 8'h00;
  logic insn_req_i = 1'b0;
  mcyc_insn_t insn_i = '0;
  logic [7:0] xrdata_i, ccr, xrdata_o;
  mcyc_phase_t phase;
  logic fetch_o, insn_done_o, core_hold_o, xrdata_valid_o;
  mcyc_xbus_t xbus_o;
  logic slow = 1'b0;
  int errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  int exp_done[$];
  logic [7:0] exp_rd[$];
  logic [31:0] lfsr = 32'h9f6530dc;
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;
  mcyc_seq mcyc_seq_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .ccr_we_i(ccr_we_i),
    .ccr_wdata_i(ccr_wdata_i), .insn_req_i(insn_req_i), .insn_i(insn_i),
    .xrdata_i(xrdata_i), .clock_control_register_o(ccr), .phase_o(phase),
    .fetch_o(fetch_o), .insn_done_o(insn_done_o), .core_hold_o(core_hold_o),
    .xrdata_o(xrdata_o), .xrdata_valid_o(xrdata_valid_o), .xbus_o(xbus_o));
  mcyc_xmem mcyc_xmem_inst (.clk_i(clk_i), .slow_i(slow), .xbus_i(xbus_o), .rdata_o(xrdata_i));
  ////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic timeout();
    errors++;
    end_sim();
  endtask : timeout
  // Holds the request until its fetch shows, then notes the done cycle.
  task automatic issue(input mcyc_insn_t op, input int len);
    int n;
    n = 0;
    insn_i = op;
    insn_req_i = 1'b1;
    do
    begin
      @(negedge clk_i);
      n++;
    end while (fetch_o !== 1'b1 && n < 99);
    if (n >= 99) timeout();
    insn_req_i = 1'b0;
    exp_done.push_back(cyc + len);
  endtask : issue
  task automatic xmove(input logic wr, input logic [15:0] a, input logic [7:0] d, input int s);
    if (!wr) exp_rd.push_back(d);
    issue('{cycles: 3'h0, xmove: 1'b1, xwrite: wr, xaddr: a, xwdata: d}, (s + 2) * 4);
  endtask : xmove
  task automatic settle();
    int n;
    n = 0;
    while (exp_done.size() != 0 || exp_rd.size() != 0)
    begin
      @(negedge clk_i);
      if (++n > 999) timeout();
    end
  endtask : settle
  task automatic set_stretch(input logic [7:0] v);
    ccr_wdata_i = v;
    ccr_we_i = 1'b1;
    @(negedge clk_i);
    ccr_we_i = 1'b0;
  endtask : set_stretch
  ////////////////////////////////////////////////////////////
  always @(negedge clk_i)
  begin
    if (insn_done_o === 1'b1)
      check(16'(cyc), exp_done.size() ? 16'(exp_done.pop_front()) : 16'hffff);
    if (xrdata_valid_o === 1'b1)
      check({8'h00, xrdata_o}, exp_rd.size() ? {8'h00, exp_rd.pop_front()} : 16'hffff);
  end
  initial
  begin
    mcyc_insn_t op;
    repeat (16) @(negedge clk_i);
    reset_n_i = 1'b1;
    check(16'(ccr), 16'h0001);
    xmove(1'b1, 16'h0010, 8'h5a, 1);
    settle();
    for (int s = 0; s < 8; s++)
    begin
      lfsr = lfsr_next(lfsr);
      set_stretch({lfsr[7:3], 3'(s)});
      check(16'(ccr[2:0]), 16'(s));
      op = '0;
      op.cycles = 3'(s);
      issue(op, 4 * (s == 0 ? 1 : (s > 5 ? 5 : s)));
      settle();
      xmove(1'b1, lfsr[23:8], lfsr[31:24], s);
      slow = (s > 1);
      xmove(1'b0, lfsr[23:8], lfsr[31:24], s);
      settle();
    end
    set_stretch(8'h07);
    xmove(1'b1, 16'h00a5, 8'hc3, 7);
    set_stretch(8'h00);
    xmove(1'b0, 16'h00a5, 8'hc3, 0);
    settle();
    end_sim();
  end
endmodule : mcyc_seq_test

// ===== bench/mcyc_xmem.sv
// External data memory model on the sequencer's bus.
// Assumes one clock; slow_i delays read data by one strobe clock.
`timescale 1ns/1ps
module mcyc_xmem (
  // Clock and mode
  input wire logic clk_i,
  input wire logic slow_i,
  // Bus
  input mcyc_pkg::mcyc_xbus_t xbus_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [256];
  logic [7:0] last_q = 8'h00;
  logic late_q = 1'b0;
  always @(posedge clk_i)
  begin
    if (!xbus_i.wr_n) mem[xbus_i.addr[7:0]] <= xbus_i.wdata;
    late_q <= !xbus_i.rd_n;
    if (!xbus_i.rd_n) last_q <= mem[xbus_i.addr[7:0]];
  end
  // A released bus shows the inverse, so stale data never passes.
  assign rdata_o = !xbus_i.rd_n && (!slow_i || late_q) ? mem[xbus_i.addr[7:0]] : ~last_q;
endmodule : mcyc_xmem

// ===== verilog/mcyc_phase.sv
// Phase generator: four clock states per machine cycle in fixed order,
// plus a falling-edge copy of the phase, used only as the sequencer's phase output.
// Assumes a clock close to 50 percent duty cycle.
`timescale 1ns/1ps
module mcyc_phase (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Phase outputs
  output mcyc_pkg::mcyc_phase_t phase_o,
  output mcyc_pkg::mcyc_phase_t phase_neg_o
);
  import mcyc_pkg::*;

  mcyc_phase_t phase_q;
  mcyc_phase_t phase_d;
  mcyc_phase_t phase_neg_q;

  // R2: fixed state order
  always_comb
  begin
    case (phase_q)
      MCYC_STATE_ONE: phase_d = MCYC_STATE_TWO;
      MCYC_STATE_TWO: phase_d = MCYC_STATE_THREE;
      MCYC_STATE_THREE: phase_d = MCYC_STATE_FOUR;
      MCYC_STATE_FOUR: phase_d = MCYC_STATE_ONE;
      default: phase_d = MCYC_STATE_ONE;
    endcase
  end

  // R1: four clock cycle
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      phase_q <= MCYC_STATE_ONE;
    else
      phase_q <= phase_d;
  end

  // R8: falling edge copy
  always_ff @(negedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      phase_neg_q <= MCYC_STATE_ONE;
    else
      phase_neg_q <= phase_q;
  end

  assign phase_o = phase_q;
  assign phase_neg_o = phase_neg_q;

endmodule : mcyc_phase

// ===== verilog/mcyc_pkg.sv
// Package for the machine cycle sequencer: phase states, timing counts,
// the stretch field layout, the decoder request bundle and the external data memory bus bundle.
// Assumes one 40 MHz clock and an active-low asynchronous reset.
package mcyc_pkg;

  // Clocks in one machine cycle.
  localparam int unsigned MCYC_CLKS_PER_CYCLE = 4;
  // Clock rate in MHz and period in ns.
  localparam int unsigned MCYC_CLK_MHZ = 40;
  localparam int unsigned MCYC_CLK_PERIOD_NS = 1000 / MCYC_CLK_MHZ;

  // Stretch field position and reset value in the clock control register.
  localparam int unsigned MCYC_STRETCH_LSB = 0;
  localparam int unsigned MCYC_STRETCH_MSB = 2;
  localparam logic [2:0] MCYC_STRETCH_RESET = 3'h1;

  // Machine cycles of an external data move beyond the stretch value.
  localparam logic [3:0] MCYC_XMOVE_BASE_CYCLES = 4'h2;
  // Strobe width in clocks at stretch 0, and added clocks per stretch step.
  localparam logic [4:0] MCYC_STROBE_BASE_CLKS = 5'h02;
  localparam logic [4:0] MCYC_STROBE_STEP_CLKS = 5'h04;

  // Longest ordinary instruction, in machine cycles.
  localparam logic [2:0] MCYC_MAX_INSN_CYCLES = 3'h5;

  // Clock states of a machine cycle, Gray coded along the fixed order.
  typedef enum logic [1:0] {
    MCYC_STATE_ONE = 2'b00,
    MCYC_STATE_TWO = 2'b01,
    MCYC_STATE_THREE = 2'b11,
    MCYC_STATE_FOUR = 2'b10
  } mcyc_phase_t;

  // Instruction request from the decoder, taken at the end of state_four.
  typedef struct packed {
    logic [2:0] cycles;
    logic xmove;
    logic xwrite;
    logic [15:0] xaddr;
    logic [7:0] xwdata;
  } mcyc_insn_t;

  // External data memory bus.
  typedef struct packed {
    logic [15:0] addr;
    logic addr_valid;
    logic rd_n;
    logic wr_n;
    logic [7:0] wdata;
    logic wdata_oe;
  } mcyc_xbus_t;

endpackage : mcyc_pkg

// ===== verilog/mcyc_seq.sv
// Machine cycle sequencer with stretched external data memory access.
// Assumes the decoder presents an instruction descriptor whenever
// insn_req_i is high, and that external memory meets the strobe width.
//
// Function
// R1: Every machine cycle is four input clock periods.
// R2: The four clock states run one, two, three, four, always.
// R3: At most one byte fetch per machine cycle, four clocks each.
// R4: Most instructions take as many machine cycles as bytes.
// R5: Jumps and calls take one extra cycle for the target address.
// R6: Half the opcodes finish in one four-clock machine cycle.
// R7: Ordinary instructions last one to five machine cycles.
// R8: Both clock edges are used internally; clock needs near 50% duty.
// R9: External move: opcode fetch cycle, then address out and access.
// R10: Stretch is bits 2 to 0 of the clock control register.
// R11: External move lasts stretch plus two machine cycles.
// R12: Stretch resets to 1, giving three-cycle external moves.
// R13: Strobe is 2 clocks at stretch 0, else 4 per step.
// R14: Stretch lengthens only external moves, holding processor state.
// R15: External device must finish within the chosen strobe width.
// R16: Stretch sampled at move start, held until access completes.
// R17: Strobe centred in access, address stable around it.
`timescale 1ns/1ps
module mcyc_seq (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Clock control register write from the core
  input wire logic ccr_we_i,
  input wire logic [7:0] ccr_wdata_i,
  // Decoder side
  input wire logic insn_req_i,
  input mcyc_pkg::mcyc_insn_t insn_i,
  // External data read byte, from a pin
  input wire logic [7:0] xrdata_i,
  // Core side outputs
  output logic [7:0] clock_control_register_o,
  output mcyc_pkg::mcyc_phase_t phase_o,
  output logic fetch_o,
  output logic insn_done_o,
  output logic core_hold_o,
  output logic [7:0] xrdata_o,
  output logic xrdata_valid_o,
  // External data memory bus
  output mcyc_pkg::mcyc_xbus_t xbus_o
);
  import mcyc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  mcyc_phase_t phase;
  mcyc_phase_t phase_neg;

  mcyc_phase mcyc_phase_inst (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .phase_o(phase),
    .phase_neg_o(phase_neg)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock control register.
  logic [7:0] ccr_q;
  logic [7:0] ccr_d;

  // R10: stretch field write
  // R12: reset to one
  always_comb
  begin
    ccr_d = ccr_we_i ? ccr_wdata_i : ccr_q;
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      ccr_q <= {5'h00, MCYC_STRETCH_RESET};
    else
      ccr_q <= ccr_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data pin synchroniser; only the second stage is read.
  logic [7:0] rsync1_q;
  logic [7:0] rsync2_q;

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rsync1_q <= 8'h00;
      rsync2_q <= 8'h00;
    end
    else
    begin
      rsync1_q <= xrdata_i;
      rsync2_q <= rsync1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction sequencing, counted in machine cycles.
  logic busy_q;
  logic busy_d;
  logic [3:0] cyc_left_q;
  logic [3:0] cyc_left_d;
  logic xmove_q;
  logic xmove_d;
  logic xwrite_q;
  logic xwrite_d;
  logic [2:0] stretch_q;
  logic [2:0] stretch_d;
  logic [15:0] xaddr_q;
  logic [15:0] xaddr_d;
  logic [7:0] xwdata_q;
  logic [7:0] xwdata_d;
  logic [4:0] strobe_clks_q;
  logic [4:0] strobe_clks_d;
  logic [5:0] acc_clk_q;
  logic [5:0] acc_clk_d;
  logic fetch_q;
  logic fetch_d;
  logic done_q;
  logic done_d;
  logic cycle_end;
  logic [2:0] cyc_req;

  assign cycle_end = (phase == MCYC_STATE_FOUR);

  always_comb
  begin
    busy_d = busy_q;
    cyc_left_d = cyc_left_q;
    xmove_d = xmove_q;
    xwrite_d = xwrite_q;
    stretch_d = stretch_q;
    xaddr_d = xaddr_q;
    xwdata_d = xwdata_q;
    strobe_clks_d = strobe_clks_q;
    acc_clk_d = acc_clk_q;
    fetch_d = 1'b0;
    done_d = 1'b0;
    cyc_req = (insn_i.cycles == 3'h0) ? 3'h1 : insn_i.cycles;
    if (cyc_req > MCYC_MAX_INSN_CYCLES)
      cyc_req = MCYC_MAX_INSN_CYCLES;
    if (busy_q && xmove_q && !(cyc_left_q == 4'h1 && cycle_end))
      acc_clk_d = acc_clk_q + 6'h01;
    if (cycle_end)
    begin
      if (busy_q && cyc_left_q != 4'h1)
      begin
        // R3: one fetch per cycle
        cyc_left_d = cyc_left_q - 4'h1;
        fetch_d = !xmove_q;
      end
      else
      begin
        done_d = busy_q;
        busy_d = 1'b0;
        xmove_d = 1'b0;
        acc_clk_d = 6'h00;
        if (insn_req_i)
        begin
          busy_d = 1'b1;
          fetch_d = 1'b1;
          xmove_d = insn_i.xmove;
          xwrite_d = insn_i.xwrite;
          xaddr_d = insn_i.xaddr;
          xwdata_d = insn_i.xwdata;
          if (insn_i.xmove)
          begin
            // R16: sample stretch once
            stretch_d = ccr_q[MCYC_STRETCH_MSB:MCYC_STRETCH_LSB];
            // R11: stretch plus two
            cyc_left_d = MCYC_XMOVE_BASE_CYCLES + {1'b0, stretch_d};
            // R13: strobe width
            strobe_clks_d = (stretch_d == 3'h0) ? MCYC_STROBE_BASE_CLKS :
              5'(MCYC_STROBE_STEP_CLKS * {2'b00, stretch_d});
          end
          else
          begin
            // R4: cycles per bytes
            // R5: jumps add one
            // R6: single cycle opcodes
            // R7: one to five
            // R14: stretch not applied
            cyc_left_d = {1'b0, cyc_req};
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      busy_q <= 1'b0;
      cyc_left_q <= 4'h0;
      xmove_q <= 1'b0;
      xwrite_q <= 1'b0;
      stretch_q <= MCYC_STRETCH_RESET;
      xaddr_q <= 16'h0000;
      xwdata_q <= 8'h00;
      strobe_clks_q <= 5'h00;
      acc_clk_q <= 6'h00;
      fetch_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      busy_q <= busy_d;
      cyc_left_q <= cyc_left_d;
      xmove_q <= xmove_d;
      xwrite_q <= xwrite_d;
      stretch_q <= stretch_d;
      xaddr_q <= xaddr_d;
      xwdata_q <= xwdata_d;
      strobe_clks_q <= strobe_clks_d;
      acc_clk_q <= acc_clk_d;
      fetch_q <= fetch_d;
      done_q <= done_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External bus. Access clocks run from 4 to 4 * cycles - 1; the strobe is centred there.
  // Read data is taken two clocks after the last strobe clock, once through the synchroniser.
  logic [5:0] acc_len;
  logic [5:0] strobe_start;
  logic strobe_win;
  logic in_access;
  logic strobe_end;
  mcyc_xbus_t xbus_q;
  mcyc_xbus_t xbus_d;
  logic hold_q;
  logic hold_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;
  logic [1:0] rcap_q;
  logic [1:0] rcap_d;

  always_comb
  begin
    acc_len = 6'(MCYC_XMOVE_BASE_CYCLES + {1'b0, stretch_q} - 4'h1) * 6'(MCYC_CLKS_PER_CYCLE);
    // R17: centred strobe
    strobe_start = 6'h04 + ((acc_len - {1'b0, strobe_clks_q}) >> 1);
    // R9: access after fetch
    in_access = busy_q && xmove_q && (acc_clk_d >= 6'h04);
    strobe_win = in_access && (acc_clk_d >= strobe_start) &&
      (acc_clk_d < strobe_start + {1'b0, strobe_clks_q});
    strobe_end = busy_q && xmove_q && !xwrite_q &&
      (acc_clk_q == strobe_start + {1'b0, strobe_clks_q} - 6'h01);
    xbus_d.addr = in_access ? xaddr_q : 16'h0000;
    xbus_d.addr_valid = in_access;
    xbus_d.rd_n = !(strobe_win && !xwrite_q);
    xbus_d.wr_n = !(strobe_win && xwrite_q);
    xbus_d.wdata = (in_access && xwrite_q) ? xwdata_q : 8'h00;
    xbus_d.wdata_oe = in_access && xwrite_q;
    // R14: hold during stretch
    hold_d = busy_d && xmove_d && (acc_clk_d >= 6'h04);
    rcap_d = {rcap_q[0], strobe_end};
    rdata_d = rcap_q[1] ? rsync2_q : rdata_q;
    rvalid_d = rcap_q[1];
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      xbus_q <= '{addr: 16'h0000, addr_valid: 1'b0, rd_n: 1'b1, wr_n: 1'b1,
        wdata: 8'h00, wdata_oe: 1'b0};
      hold_q <= 1'b0;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      rcap_q <= 2'b00;
    end
    else
    begin
      xbus_q <= xbus_d;
      hold_q <= hold_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      rcap_q <= rcap_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign clock_control_register_o = ccr_q;
  // R8: falling edge view
  assign phase_o = phase_neg;
  assign fetch_o = fetch_q;
  assign insn_done_o = done_q;
  assign core_hold_o = hold_q;
  assign xrdata_o = rdata_q;
  assign xrdata_valid_o = rvalid_q;
  assign xbus_o = xbus_q;

endmodule : mcyc_seq
